// [design/dmx_crosspoint_gen.sv]
// divide and multiply crosspoint generator with its control-pulse gates
`timescale 1ns/1ns

module dmx_crosspoint_gen (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [dmx_pkg::TP_W-1:0] time_pulse,
  input wire dmx_pkg::dmx_cmd_t cmd,
  input wire logic twelfth_use_flag,
  input wire logic phase_four,
  input wire logic [1:0] branch_ff_pair,
  input wire logic [dmx_pkg::LREG_W:1] lreg,
  input wire logic xpoint_t2_seven,
  input wire logic xpoint_t2_b_raw,
  input wire logic xpoint_t8_ten_raw,
  output dmx_pkg::dmx_xp_t xp,
  output dmx_pkg::dmx_cp_t cp,
  output logic prior_step_ff,
  output logic eac_blocked,
  output logic time_pulse_fault
);
  import dmx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // true when the present time pulse is one of the group in mask
  function automatic logic tp_in(input logic [TP_W-1:0] tp, input logic [TP_W-1:0] mask);
    tp_in = |(tp & mask);
  endfunction

  // true when the vector has exactly one bit set
  function automatic logic one_hot(input logic [TP_W-1:0] v);
    logic [TP_W-1:0] low;
    low = v - 12'h001;
    one_hot = (v != '0) && ((v & low) == '0);
  endfunction

  // multiplier-bit state to {shifted write, read b, carry in, carry control}
  function automatic logic [3:0] ls_step(input logic [2:0] s);
    unique case (s)
      3'h0: ls_step = 4'h0;
      LS_001: ls_step = 4'h4;
      LS_010: ls_step = 4'hC;
      LS_011: ls_step = 4'h3;
      LS_100: ls_step = 4'h4;
      LS_101: ls_step = 4'hC;
      LS_110: ls_step = 4'h3;
      LS_111: ls_step = 4'h1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // time pulse qualification

  logic tp_ok;
  logic [TP_W-1:0] tp;
  logic fault_d;

  // a broken timing chain must not fire several register strobes at once
  always_comb begin
    tp_ok = one_hot(time_pulse);
    tp = tp_ok ? time_pulse : '0;
    fault_d = (time_pulse != '0) && !tp_ok;
  end

  ////////////////////////////////////////////////////////////////////////////
  // divide crosspoints

  logic special_div_en;
  logic dv_one;
  logic dv_two;
  logic dv_three;
  logic dv_stage;

  always_comb begin
    // subinstruction zero runs on the conventional circuits,
    // so the special circuit stays quiet there
    special_div_en = !cmd.div_sub_zero;
    dv_one = 1'h0;
    dv_two = 1'h0;
    dv_three = 1'h0;
    dv_stage = 1'h0;
    if (special_div_en) begin
      if (cmd.divide_cmd_all_stages && tp[T01]) begin
        dv_one = 1'h1;
      end
      if (cmd.divide_cmd_later_stages && tp_in(tp, TPM_DIV_ONE_LATER)) begin
        dv_one = 1'h1;
      end
      if (cmd.divide_final_subcmd && tp[T04]) begin
        dv_one = 1'h1;
      end
      if (cmd.divide_cmd_all_stages && tp[T02]) begin
        dv_two = 1'h1;
      end
      if (cmd.divide_cmd_later_stages && tp_in(tp, TPM_DIV_TWO_LATER)) begin
        dv_two = 1'h1;
      end
      if (cmd.divide_cmd_later_stages && twelfth_use_flag && tp_in(tp, TPM_DIV_THREE_LATER)) begin
        dv_three = 1'h1;
      end
    end
    // the stage step is involuntary through every divide subinstruction
    if (cmd.divide_active && tp[T03]) begin
      dv_stage = 1'h1;
      dv_three = 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiply crosspoints

  logic [2:0] lstate;
  logic mp_odd;
  logic mp_even;
  logic mp_a;
  logic mp_b;
  logic mp_c;
  logic mp_cctl;
  logic mp_cin;
  logic [3:0] ls_bits;

  always_comb begin
    lstate = {lreg[L_BIT_HI], lreg[L_BIT_MID], lreg[L_BIT_LO]};
    mp_odd = (cmd.mult_sub_one && tp_in(tp, TPM_ODD))
      || (cmd.mult_sub_three && xpoint_t2_seven && tp[T02]);
    mp_even = (cmd.mult_sub_one && tp_in(tp, TPM_MP1_EVEN))
      || (cmd.mult_sub_three && tp_in(tp, TPM_MP3_EVEN));
    // step pulses ride only on the odd crosspoint
    ls_bits = ls_step(lstate);
    mp_b = mp_odd && ls_bits[3];
    mp_a = mp_odd && !ls_bits[3];
    mp_c = mp_odd && ls_bits[2];
    mp_cin = mp_odd && ls_bits[1];
    mp_cctl = mp_odd && ls_bits[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // involuntary crosspoint gating and adder carry mode pulses

  logic inv_t2_b;
  logic inv_t8_ten;
  logic eac_on;
  logic eac_off;

  always_comb begin
    inv_t2_b = xpoint_t2_b_raw && !cmd.mult_sub_one && !cmd.mult_sub_three;
    inv_t8_ten = xpoint_t8_ten_raw && !cmd.mult_sub_one;
    eac_on = cmd.mult_sub_zero && tp[T10];
    eac_off = cmd.mult_sub_three && tp[T06];
  end

  ////////////////////////////////////////////////////////////////////////////
  // control pulse gates

  dmx_xp_t xp_d;
  dmx_cp_t cp_d;
  logic sign_test;

  always_comb begin
    xp_d = '0;
    xp_d.div_xpoint_one = dv_one;
    xp_d.div_xpoint_two = dv_two;
    xp_d.div_xpoint_three = dv_three;
    xp_d.divide_stage_step = dv_stage;
    xp_d.mult_odd_xpoint = mp_odd;
    xp_d.mult_even_xpoint = mp_even;
    xp_d.mult_xpoint_a = mp_a;
    xp_d.mult_xpoint_b = mp_b;
    xp_d.mult_xpoint_c = mp_c;
    xp_d.mult_carry_ctl = mp_cctl;
    xp_d.mult_carry_in_xpoint = mp_cin;
    xp_d.xpoint_t2_b = inv_t2_b;
    xp_d.xpoint_t8_ten = inv_t8_ten;

    // shared control pulses are simple ORs of their crosspoints
    cp_d = '0;
    cp_d.adder_to_x = dv_one || mp_odd;
    cp_d.lreg_to_g_shift = dv_one || mp_odd;
    cp_d.read_b = dv_one || mp_c;
    cp_d.write_y_shifted = dv_one || mp_b;
    cp_d.write_y = mp_a;
    cp_d.read_g = dv_two;
    sign_test = dv_two;
    cp_d.test_sign_u = sign_test;
    cp_d.write_l = dv_two;
    cp_d.read_u = dv_three || mp_even;
    cp_d.write_b = dv_three;
    // on a phase-four sign test, exactly one of the two, picked by the upper branch flip-flop
    cp_d.clear_x_conditional = sign_test && phase_four && !branch_ff_pair[BR_HI];
    cp_d.read_b_one_fill = sign_test && phase_four && branch_ff_pair[BR_HI];
    cp_d.read_c = mp_cin;
    cp_d.carry_in_pulse = mp_cin;
    cp_d.g_to_l_shift = mp_even;
    cp_d.write_a_l_shift = mp_even;
    cp_d.mult_carry_ctl = mp_cctl;
    cp_d.eac_inhibit_pulse = eac_on;
    cp_d.eac_release_pulse = eac_off;
  end

  ////////////////////////////////////////////////////////////////////////////
  // prior-step flop

  logic prior_d;
  logic prior_q;

  always_comb begin
    prior_d = prior_q;
    // set wins over clear; the clear pulses never coincide with a set anyway
    if (dv_one) begin
      prior_d = 1'h1;
    end else if (tp_in(tp, TPM_PRIOR_CLEAR)) begin
      prior_d = 1'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prior_q <= RST_VAL;
    end else begin
      prior_q <= prior_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // end-around-carry block flop of the adder

  logic eac_d;
  logic eac_q;

  always_comb begin
    eac_d = eac_q;
    // inhibit wins, so a clash can never reopen end-around carry inside a multiply
    if (eac_on) begin
      eac_d = 1'h1;
    end else if (eac_off) begin
      eac_d = 1'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      eac_q <= RST_VAL;
    end else begin
      eac_q <= eac_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output registers: every pulse is delayed one clock so all line up

  dmx_xp_t xp_q;
  dmx_cp_t cp_q;
  logic fault_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      xp_q <= '0;
      cp_q <= '0;
      fault_q <= RST_VAL;
    end else begin
      xp_q <= xp_d;
      cp_q <= cp_d;
      fault_q <= fault_d;
    end
  end

  // flop outputs share the edge with the registered crosspoint one
  always_comb begin
    xp = xp_q;
    cp = cp_q;
    prior_step_ff = prior_q;
    eac_blocked = eac_q;
    time_pulse_fault = fault_q;
  end

endmodule

// [design/dmx_pkg.sv]
// constants and carrier types for the divide and multiply crosspoint generator
package dmx_pkg;

  // time pulse positions, T01 sits in bit 0 of the one-hot time-pulse vector
  localparam int TP_W = 12;
  localparam int T01 = 0;
  localparam int T02 = 1;
  localparam int T03 = 2;
  localparam int T04 = 3;
  localparam int T05 = 4;
  localparam int T06 = 5;
  localparam int T08 = 7;
  localparam int T10 = 9;
  localparam int T11 = 10;

  // groups of time pulses used by the decoders
  localparam logic [TP_W-1:0] TPM_DIV_ONE_LATER = 12'h248;   // T04 T07 T10
  localparam logic [TP_W-1:0] TPM_DIV_TWO_LATER = 12'h490;   // T05 T08 T11
  localparam logic [TP_W-1:0] TPM_DIV_THREE_LATER = 12'h920; // T06 T09 T12
  localparam logic [TP_W-1:0] TPM_PRIOR_CLEAR = 12'h492;     // T02 T05 T08 T11
  localparam logic [TP_W-1:0] TPM_ODD = 12'h555;             // T01 .. T11 odd
  localparam logic [TP_W-1:0] TPM_MP1_EVEN = 12'h2AA;        // T02 .. T10 even
  localparam logic [TP_W-1:0] TPM_MP3_EVEN = 12'h005;        // T01 T03

  // multiplier bits of register L, numbered 1 .. 16
  localparam int LREG_W = 16;
  localparam int L_BIT_HI = 15;
  localparam int L_BIT_MID = 2;
  localparam int L_BIT_LO = 1;

  // multiplier-bit states, ordered {bit 15, bit 2, bit 1}
  localparam logic [2:0] LS_001 = 3'h1;
  localparam logic [2:0] LS_010 = 3'h2;
  localparam logic [2:0] LS_011 = 3'h3;
  localparam logic [2:0] LS_100 = 3'h4;
  localparam logic [2:0] LS_101 = 3'h5;
  localparam logic [2:0] LS_110 = 3'h6;
  localparam logic [2:0] LS_111 = 3'h7;

  // branch flip-flop pair bit that splits 0X from 1X
  localparam int BR_HI = 1;

  // reset value of every flip-flop in the block
  localparam logic RST_VAL = 1'h0;

  typedef struct packed {
    logic divide_cmd_all_stages;
    logic divide_cmd_later_stages;
    logic divide_final_subcmd;
    logic div_sub_zero;
    logic div_sub_one;
    logic divide_active;
    logic mult_sub_zero;
    logic mult_sub_one;
    logic mult_sub_three;
  } dmx_cmd_t;

  typedef struct packed {
    logic div_xpoint_one;
    logic div_xpoint_two;
    logic div_xpoint_three;
    logic divide_stage_step;
    logic mult_odd_xpoint;
    logic mult_even_xpoint;
    logic mult_xpoint_a;
    logic mult_xpoint_b;
    logic mult_xpoint_c;
    logic mult_carry_ctl;
    logic mult_carry_in_xpoint;
    logic xpoint_t2_b;
    logic xpoint_t8_ten;
  } dmx_xp_t;

  typedef struct packed {
    logic adder_to_x;
    logic lreg_to_g_shift;
    logic read_b;
    logic write_y_shifted;
    logic write_y;
    logic read_g;
    logic test_sign_u;
    logic write_l;
    logic read_u;
    logic write_b;
    logic clear_x_conditional;
    logic read_b_one_fill;
    logic read_c;
    logic carry_in_pulse;
    logic g_to_l_shift;
    logic write_a_l_shift;
    logic mult_carry_ctl;
    logic eac_inhibit_pulse;
    logic eac_release_pulse;
  } dmx_cp_t;

endpackage

// [verif/dmx_timing_model.sv]
// time-pulse ring of the timing logic that feeds the crosspoint generator
`timescale 1ns/1ns

module dmx_timing_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic glitch,
  output logic [dmx_pkg::TP_W-1:0] time_pulse
);
  import dmx_pkg::*;
  logic [TP_W-1:0] ring_q;
  logic [TP_W-1:0] ring_d;
  always_comb begin
    ring_d = {ring_q[TP_W-2:0], ring_q[TP_W-1]};
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ring_q <= 12'h001;
    end else begin
      ring_q <= ring_d;
    end
  end
  // a second pulse only when the bench orders a fault
  assign time_pulse = glitch ? (ring_q | {ring_q[5:0], ring_q[11:6]}) : ring_q;
endmodule

// [verif/dmx_checker_assertions.sv]
// port-level assertions for the crosspoint generator
`timescale 1ns/1ns

module dmx_checker (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [dmx_pkg::TP_W-1:0] time_pulse,
  input wire dmx_pkg::dmx_cmd_t cmd,
  input wire logic twelfth_use_flag,
  input wire dmx_pkg::dmx_xp_t xp,
  input wire dmx_pkg::dmx_cp_t cp,
  input wire logic prior_step_ff,
  input wire logic eac_blocked,
  input wire logic time_pulse_fault
);
  import dmx_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////
  property p_d1;
    resetn && cmd.divide_cmd_all_stages && !cmd.div_sub_zero && time_pulse == 12'h001 |=> xp.div_xpoint_one;
  endproperty
  a_d1: assert property (p_d1) else $error("no xpoint one at first pulse");
  property p_d1l;
    cmd.divide_cmd_later_stages && !cmd.div_sub_zero && $onehot(time_pulse) && |(time_pulse & 12'h248)
      |=> xp.div_xpoint_one;
  endproperty
  a_d1l: assert property (p_d1l) else $error("no later xpoint one");
  property p_cp1;
    xp.div_xpoint_one |-> cp.adder_to_x && cp.lreg_to_g_shift && cp.read_b && cp.write_y_shifted && prior_step_ff;
  endproperty
  a_cp1: assert property (p_cp1) else $error("xpoint one pulses");
  property p_pclr; $onehot(time_pulse) && |(time_pulse & 12'h492) |=> !prior_step_ff; endproperty
  a_pclr: assert property (p_pclr) else $error("prior step not cleared");
  property p_d2;
    cmd.divide_cmd_later_stages && !cmd.div_sub_zero && time_pulse == 12'h010
      |=> xp.div_xpoint_two && cp.test_sign_u && cp.write_l;
  endproperty
  a_d2: assert property (p_d2) else $error("no xpoint two");
  property p_stg; cmd.divide_active && time_pulse == 12'h004 |=> xp.div_xpoint_three && cp.read_u && cp.write_b; endproperty
  a_stg: assert property (p_stg) else $error("no stage step");
  property p_d3;
    $onehot(time_pulse) && |(time_pulse & 12'h920) && !(cmd.divide_cmd_later_stages && twelfth_use_flag)
      |=> !xp.div_xpoint_three;
  endproperty
  a_d3: assert property (p_d3) else $error("stray xpoint three");
  property p_odd; cmd.mult_sub_one && time_pulse == 12'h400 |=> xp.mult_odd_xpoint && cp.adder_to_x; endproperty
  a_odd: assert property (p_odd) else $error("no odd xpoint");
  property p_step;
    xp.mult_odd_xpoint == (xp.mult_xpoint_a ^ xp.mult_xpoint_b)
      && (xp.mult_odd_xpoint || !(xp.mult_xpoint_c || xp.mult_carry_ctl || xp.mult_carry_in_xpoint));
  endproperty
  a_step: assert property (p_step) else $error("step pulse without odd xpoint");
  property p_inv; cmd.mult_sub_one || cmd.mult_sub_three |=> !xp.xpoint_t2_b; endproperty
  a_inv: assert property (p_inv) else $error("involuntary pulse passed");
  property p_inv8; cmd.mult_sub_one |=> !xp.xpoint_t8_ten; endproperty
  a_inv8: assert property (p_inv8) else $error("involuntary T08 pulse passed");
  property p_rel; cmd.mult_sub_three && time_pulse == 12'h020 |=> cp.eac_release_pulse && !eac_blocked; endproperty
  a_rel: assert property (p_rel) else $error("carry not released");
  property p_eac; cmd.mult_sub_zero && time_pulse == 12'h200 |=> cp.eac_inhibit_pulse && eac_blocked; endproperty
  a_eac: assert property (p_eac) else $error("carry not inhibited");
  property p_br; !(cp.clear_x_conditional && cp.read_b_one_fill); endproperty
  a_br: assert property (p_br) else $error("both branch pulses");
  property p_flt; resetn && !$onehot0(time_pulse) |=> time_pulse_fault && !xp.div_xpoint_one; endproperty
  a_flt: assert property (p_flt) else $error("bad time pulse not refused");
endmodule

bind dmx_crosspoint_gen dmx_checker u_chk (.clk_sys, .resetn, .time_pulse, .cmd, .twelfth_use_flag,
  .xp, .cp, .prior_step_ff, .eac_blocked, .time_pulse_fault);

// [verif/tb.sv]
// random self-checking bench with a cycle model of the generator
`timescale 1ns/1ns

module tb;
  import dmx_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic glitch = 1'b0;
  logic [TP_W-1:0] time_pulse;
  dmx_cmd_t cmd = 9'h000;
  logic twelfth_use_flag = 1'b0, phase_four = 1'b0, xpoint_t2_seven = 1'b0;
  logic xpoint_t2_b_raw = 1'b0, xpoint_t8_ten_raw = 1'b0;
  logic [1:0] branch_ff_pair = 2'h0;
  logic [LREG_W:1] lreg = 16'h0000;
  dmx_xp_t xp, ex_xp;
  dmx_cp_t cp, ex_cp;
  logic prior_step_ff, eac_blocked, time_pulse_fault;
  logic ex_pri = 1'b0, ex_eac = 1'b0, ex_flt = 1'b0, armed = 1'b0;
  int err_total = 0;
  int checked = 0;
  always #20 clk_sys = ~clk_sys;
  dmx_timing_model u_tm (.clk_sys, .resetn, .glitch, .time_pulse);
  dmx_crosspoint_gen uut (.clk_sys, .resetn, .time_pulse, .cmd, .twelfth_use_flag, .phase_four, .branch_ff_pair,
    .lreg, .xpoint_t2_seven, .xpoint_t2_b_raw, .xpoint_t8_ten_raw, .xp, .cp, .prior_step_ff, .eac_blocked,
    .time_pulse_fault);
  ////////////////////////////////////////////////////////////////
  task automatic predict();
    int t;
    logic d1, d2, d3, od, ev, sp;
    logic [2:0] s;
    t = $onehot(time_pulse) ? $clog2(time_pulse) : -1;
    s = {lreg[15], lreg[2], lreg[1]};
    sp = !cmd.div_sub_zero;
    d1 = sp && ((cmd.divide_cmd_all_stages && t == 0) || (cmd.divide_cmd_later_stages && t inside {3, 6, 9})
      || (cmd.divide_final_subcmd && t == 3));
    d2 = sp && ((cmd.divide_cmd_all_stages && t == 1) || (cmd.divide_cmd_later_stages && t inside {4, 7, 10}));
    ex_xp = '0;
    ex_xp.divide_stage_step = cmd.divide_active && t == 2;
    ex_xp.xpoint_t2_b = xpoint_t2_b_raw && !cmd.mult_sub_one && !cmd.mult_sub_three;
    ex_xp.xpoint_t8_ten = xpoint_t8_ten_raw && !cmd.mult_sub_one;
    d3 = ex_xp.divide_stage_step || (sp && cmd.divide_cmd_later_stages && twelfth_use_flag && t inside {5, 8, 11});
    od = (cmd.mult_sub_one && t inside {0, 2, 4, 6, 8, 10}) || (cmd.mult_sub_three && xpoint_t2_seven && t == 1);
    ev = (cmd.mult_sub_one && t inside {1, 3, 5, 7, 9}) || (cmd.mult_sub_three && t inside {0, 2});
    {ex_xp.div_xpoint_one, ex_xp.div_xpoint_two, ex_xp.div_xpoint_three} = {d1, d2, d3};
    {ex_xp.mult_odd_xpoint, ex_xp.mult_even_xpoint} = {od, ev};
    ex_xp.mult_xpoint_b = od && s inside {3'h2, 3'h5};
    ex_xp.mult_xpoint_a = od && !ex_xp.mult_xpoint_b;
    ex_xp.mult_xpoint_c = od && s inside {3'h1, 3'h2, 3'h4, 3'h5};
    ex_xp.mult_carry_in_xpoint = od && s inside {3'h3, 3'h6};
    ex_xp.mult_carry_ctl = od && s inside {3'h3, 3'h6, 3'h7};
    ex_cp = '0;
    {ex_cp.adder_to_x, ex_cp.lreg_to_g_shift} = {2{d1 || od}};
    ex_cp.read_b = d1 || ex_xp.mult_xpoint_c;
    ex_cp.write_y_shifted = d1 || ex_xp.mult_xpoint_b;
    ex_cp.write_y = ex_xp.mult_xpoint_a;
    {ex_cp.read_g, ex_cp.test_sign_u, ex_cp.write_l} = {3{d2}};
    ex_cp.clear_x_conditional = d2 && phase_four && !branch_ff_pair[1];
    ex_cp.read_b_one_fill = d2 && phase_four && branch_ff_pair[1];
    {ex_cp.read_u, ex_cp.write_b} = {d3 || ev, d3};
    {ex_cp.read_c, ex_cp.carry_in_pulse} = {2{ex_xp.mult_carry_in_xpoint}};
    {ex_cp.g_to_l_shift, ex_cp.write_a_l_shift} = {2{ev}};
    ex_cp.mult_carry_ctl = ex_xp.mult_carry_ctl;
    ex_cp.eac_inhibit_pulse = cmd.mult_sub_zero && t == 9;
    ex_cp.eac_release_pulse = cmd.mult_sub_three && t == 5;
    ex_pri = d1 || (ex_pri && !(t inside {1, 4, 7, 10}));
    ex_eac = ex_cp.eac_inhibit_pulse || (ex_eac && !ex_cp.eac_release_pulse);
    ex_flt = !$onehot0(time_pulse);
  endtask
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // involuntary pulses pass with only the multiply inhibits applied; the others lie outside this block
  always @(negedge clk_sys) begin
    if (armed && resetn) begin
      chk(xp === ex_xp, "crosspoints");
      chk(cp === ex_cp, "control pulses");
      chk({prior_step_ff, eac_blocked, time_pulse_fault} === {ex_pri, ex_eac, ex_flt}, "flops");
    end
    armed = resetn;
    if (resetn) begin
      predict();
    end else begin
      {ex_pri, ex_eac} = 2'h0;
    end
  end
  initial begin
    void'($urandom(32'h96B44E62));
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_sys);
      // every command bit is random, so the subinstruction-zero gating of the divide circuit is exercised
      cmd <= dmx_cmd_t'(9'($urandom));
      {twelfth_use_flag, phase_four, branch_ff_pair, xpoint_t2_seven, xpoint_t2_b_raw, xpoint_t8_ten_raw}
        <= 7'($urandom);
      lreg <= 16'($urandom);
      glitch <= ($urandom % 16) == 0;
      resetn <= !(i inside {1500, 1501});
    end
    end_sim();
  end
endmodule
